// *** core/pio_pkg.sv ***
// Package for the parallel I/O pin control block: widths, reset values, codes and carriers
package pio_pkg;
	localparam int PIO_WIDTH = 8;
	localparam int PIO_SYNC_STAGES = 2;
	localparam logic [1:0] PIO_SUPPLY_FULL_DRIVE = 2'h3;
	localparam logic PIO_REG_REF_OFF = 1'h0;
	localparam logic [PIO_WIDTH-1:0] PIO_DATA_RESET = 8'h00;
	localparam logic [PIO_WIDTH-1:0] PIO_DIR_RESET = 8'h00;
	localparam logic [PIO_WIDTH-1:0] PIO_PULL_RESET = 8'h00;
	localparam logic [PIO_WIDTH-1:0] PIO_SLEW_RESET = 8'hFF;
	localparam logic [PIO_WIDTH-1:0] PIO_DRIVE_RESET = 8'h00;
	localparam logic [PIO_WIDTH-1:0] PIO_ZERO = 8'h00;
	// Pins 5 and 4 of the port are shared with the LCD
	localparam logic [PIO_WIDTH-1:0] PIO_LCD_SHARED = 8'h30;
	localparam logic [PIO_WIDTH-1:0] PIO_OUT_ONLY = 8'h00;

	// Which register a write is aimed at
	typedef enum logic [2:0] {
		PIO_SEL_DATA,
		PIO_SEL_DIR,
		PIO_SEL_PULL,
		PIO_SEL_SLEW,
		PIO_SEL_DRIVE
	} pio_sel_t;

	// Page of the register map that an access falls in
	typedef enum logic {
		PIO_PAGE_ZERO,
		PIO_PAGE_HIGH
	} pio_page_t;

	// Register write request
	typedef struct packed {
		logic wr;
		pio_page_t page;
		pio_sel_t sel;
		logic [PIO_WIDTH-1:0] data;
	} pio_wr_t;

	// Shared function requests per pin
	typedef struct packed {
		logic [PIO_WIDTH-1:0] dig_en;
		logic [PIO_WIDTH-1:0] dig_out;
		logic [PIO_WIDTH-1:0] dig_oe;
		logic [PIO_WIDTH-1:0] ana_en;
	} pio_share_t;

	// Pad controls per pin
	typedef struct packed {
		logic [PIO_WIDTH-1:0] out;
		logic [PIO_WIDTH-1:0] oe;
		logic [PIO_WIDTH-1:0] ie;
		logic [PIO_WIDTH-1:0] pull_up;
		logic [PIO_WIDTH-1:0] slew;
		logic [PIO_WIDTH-1:0] high_drive;
	} pio_pad_t;
endpackage

// *** core/pio_port.sv ***
// Parallel I/O port: data, direction and pad controls, sharing and stop-mode retention
// How it works
// [R1] Direction bit enables the output buffer and picks latch or pin for reads.
// [R2] Input buffer stays on except for analog or output-only pins.
// [R3] Enabled digital peripheral drives output buffer; direction still picks read source.
// [R4] Analog function disables both input and output buffers.
// [R5] Input-direction bit with disabled input buffer reads zero.
// [R6] Analog function wins over a digital function on the same pin.
// [R7] Software should load data before turning a pin to output.
// [R8] Each pin's pull-enable bit turns on its own pull-up.
// [R9] Pull-up off for outputs, except LCD-shared open-drain outputs.
// [R10] Any analog or peripheral function forces the pull-up off.
// [R11] Slew bit limits output edge rate; no effect for inputs.
// [R12] Drive bit selects high drive when set, low when clear.
// [R13] LCD-shared pins are open drain, driving low only, except in the [R19] full-drive setting.
// [R14] Partial power-down stop freezes output latches as before the stop.
// [R15] Software checks the power-down flag and reinitialises or restores I/O.
// [R16] Pins stay latched and I/O access blocked until acknowledge is written; the code blocks register writes only, rd_data_o still updates.
// [R17] LCD running in stop keeps LCD-pin drive mode on recovery.
// [R18] Light stop keeps all I/O state and works at once on recovery.
// [R19] Pins 5 and 4 fully driven only at supply 11 with reference off.
// [R20] Data and direction in zero page; pull, slew, drive in high page.
// [R21] Reset: inputs, slew on, low drive, pulls off, sharing off.
// [R22] Writes latch all data bits; driven only on outputs; reset clears.
// [R23] Pin input passes a two-stage synchroniser before being read.
// [R24] Open-drain pin with output one releases its enable.
`timescale 1ns/1ns
`default_nettype none
module pio_port
	import pio_pkg::*;
#(
	parameter int WIDTH = PIO_WIDTH,
	parameter logic [WIDTH-1:0] LCD_SHARED = PIO_LCD_SHARED,
	parameter logic [WIDTH-1:0] OUT_ONLY = PIO_OUT_ONLY
)
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire pio_wr_t wr_i,
	output logic [WIDTH-1:0] rd_data_o,
	output logic [WIDTH-1:0] dir_o,
	output logic [WIDTH-1:0] pull_o,
	output logic [WIDTH-1:0] slew_o,
	output logic [WIDTH-1:0] drive_o,
	input wire pio_share_t share_i,
	input wire logic [1:0] lcd_supply_select_i,
	input wire logic regulated_reference_enable_i,
	input wire logic lcd_in_stop_i,
	input wire logic partial_powerdown_stop_i,
	input wire logic light_stop_i,
	input wire logic partial_powerdown_ack_i,
	output logic partial_powerdown_flag_o,
	output logic io_locked_o,
	input wire logic [WIDTH-1:0] pin_i,
	output pio_pad_t pad_o
);
	logic [WIDTH-1:0] data_latch;
	logic [WIDTH-1:0] pin_direction_bit;
	logic [WIDTH-1:0] pin_pull_enable_bit;
	logic [WIDTH-1:0] pin_slew_enable_bit;
	logic [WIDTH-1:0] pin_drive_strength_bit;
	logic [WIDTH-1:0] pin_sync;
	logic io_locked;
	logic ppd_flag;
	logic lcd_full_drive;
	logic lcd_od_frozen;
	logic next_lcd_od;
	logic write_ok;
	pio_pad_t next_pad;
	pio_pad_t pad;
	logic [WIDTH-1:0] ana;
	logic [WIDTH-1:0] dig;
	logic [WIDTH-1:0] od;
	logic [WIDTH-1:0] in_en;
	logic [WIDTH-1:0] out_val;
	logic [WIDTH-1:0] out_drive;

	pio_sync #(
		.WIDTH(WIDTH)
	) u_sync (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.async_i(pin_i),
		.sync_o(pin_sync)
	); // see [R23]

	// Register writes are refused while the port is held after a power-down stop
	assign write_ok = wr_i.wr && !io_locked && !partial_powerdown_stop_i; // see [R16]

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			data_latch <= PIO_DATA_RESET; // see [R22]
		else if (write_ok && wr_i.page == PIO_PAGE_ZERO && wr_i.sel == PIO_SEL_DATA)
			data_latch <= wr_i.data; // see [R22] [R20]
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			pin_direction_bit <= PIO_DIR_RESET; // see [R21]
		else if (write_ok && wr_i.page == PIO_PAGE_ZERO && wr_i.sel == PIO_SEL_DIR)
			pin_direction_bit <= wr_i.data; // see [R20]
	end

	// Pad control registers live in the high page only
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			pin_pull_enable_bit <= PIO_PULL_RESET; // see [R21]
			pin_slew_enable_bit <= PIO_SLEW_RESET;
			pin_drive_strength_bit <= PIO_DRIVE_RESET;
		end
		else if (write_ok && wr_i.page == PIO_PAGE_HIGH)
		begin
			if (wr_i.sel == PIO_SEL_PULL)
				pin_pull_enable_bit <= wr_i.data; // see [R8] [R20]
			if (wr_i.sel == PIO_SEL_SLEW)
				pin_slew_enable_bit <= wr_i.data;
			if (wr_i.sel == PIO_SEL_DRIVE)
				pin_drive_strength_bit <= wr_i.data;
		end
	end

	// Lock on partial power-down; hold until software acknowledges afterwards
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			io_locked <= 1'b0;
			ppd_flag <= 1'b0;
		end
		else if (partial_powerdown_stop_i)
		begin
			io_locked <= 1'b1; // see [R14]
			ppd_flag <= 1'b1;
		end
		else if (io_locked && partial_powerdown_ack_i)
		begin
			io_locked <= 1'b0; // see [R16]
			ppd_flag <= 1'b0;
		end
	end

	assign lcd_full_drive = (lcd_supply_select_i == PIO_SUPPLY_FULL_DRIVE)
		&& (regulated_reference_enable_i == PIO_REG_REF_OFF); // see [R19]

	// LCD pin drive mode is kept through stop when the LCD runs in stop
	assign next_lcd_od = (lcd_in_stop_i && (partial_powerdown_stop_i || light_stop_i))
		? lcd_od_frozen : !lcd_full_drive; // see [R17]

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			lcd_od_frozen <= 1'b1;
		else
			lcd_od_frozen <= next_lcd_od;
	end

	always_comb
	begin
		ana = share_i.ana_en;
		dig = share_i.dig_en & ~ana; // see [R6]
		od = LCD_SHARED & {WIDTH{lcd_od_frozen}}; // see [R13]
		in_en = ~(ana | OUT_ONLY); // see [R2] [R4]
		out_val = (share_i.dig_out & dig) | (data_latch & ~dig); // see [R3]
		out_drive = ((share_i.dig_oe & dig) | (pin_direction_bit & ~dig)) & ~ana; // see [R1] [R4]
		next_pad.out = out_val & ~od;
		// Open drain releases the pin for a one, so the pull-up sets the level
		next_pad.oe = out_drive & ~(od & out_val); // see [R24] [R13]
		next_pad.ie = in_en;
		next_pad.pull_up = pin_pull_enable_bit & ~ana & ~share_i.dig_en
			& (~out_drive | od); // see [R9] [R10]
		next_pad.slew = pin_slew_enable_bit & out_drive; // see [R11]
		next_pad.high_drive = pin_drive_strength_bit & out_drive; // see [R12]
	end

	// Pads freeze on partial power-down; light stop leaves them running
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			pad.out <= PIO_ZERO;
			pad.oe <= PIO_ZERO;
			pad.ie <= ~OUT_ONLY;
			pad.pull_up <= PIO_ZERO;
			pad.slew <= PIO_ZERO;
			pad.high_drive <= PIO_ZERO;
		end
		else if (!io_locked && !partial_powerdown_stop_i)
			pad <= next_pad; // see [R14] [R16] [R18]
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			rd_data_o <= PIO_ZERO;
		else
			rd_data_o <= (pin_direction_bit & data_latch)
				| (~pin_direction_bit & pin_sync & in_en); // see [R1] [R5] [R3]
	end

	assign pad_o = pad;
	assign dir_o = pin_direction_bit;
	assign pull_o = pin_pull_enable_bit;
	assign slew_o = pin_slew_enable_bit;
	assign drive_o = pin_drive_strength_bit;
	assign partial_powerdown_flag_o = ppd_flag; // see [R15]
	assign io_locked_o = io_locked;
endmodule
`default_nettype wire

// *** core/pio_sync.sv ***
// Two-stage level synchroniser, one per pin
`timescale 1ns/1ns
`default_nettype none
module pio_sync
	import pio_pkg::*;
#(
	parameter int WIDTH = PIO_WIDTH
)
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] stage_one;

	genvar g;
	generate
		for (g = 0; g < WIDTH; g++)
		begin : g_bit
			always_ff @(posedge sys_clk_i)
			begin
				if (rst_i)
				begin
					stage_one[g] <= 1'b0;
					sync_o[g] <= 1'b0;
				end
				else
				begin
					stage_one[g] <= async_i[g];
					sync_o[g] <= stage_one[g];
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// *** verification/pio_load.sv ***
// Outside world on the port pins: driven level, pull-up or a floating pattern
`timescale 1ns/1ns
`default_nettype none
module pio_load
	import pio_pkg::*;
(
	input wire pio_pad_t pad_i,
	input wire logic [PIO_WIDTH-1:0] ext_i,
	output logic [PIO_WIDTH-1:0] pin_o
);
	// A released pin without pull-up takes whatever the bench puts on the board
	always_comb
		for (int k = 0; k < PIO_WIDTH; k++)
			pin_o[k] = pad_i.oe[k] ? pad_i.out[k] : (pad_i.pull_up[k] | ext_i[k]);
endmodule
`default_nettype wire

// *** verification/pio_port_asserts.sv ***
// Checker for the parallel I/O port, bound to its ports
`timescale 1ns/1ns
`default_nettype none
module pio_port_asserts
	import pio_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [PIO_WIDTH-1:0] rd_data_o,
	input wire logic [PIO_WIDTH-1:0] dir_o,
	input wire logic [PIO_WIDTH-1:0] pull_o,
	input wire logic [PIO_WIDTH-1:0] drive_o,
	input wire logic [PIO_WIDTH-1:0] slew_o,
	input wire pio_share_t share_i,
	input wire logic [1:0] lcd_supply_select_i,
	input wire logic regulated_reference_enable_i,
	input wire logic lcd_in_stop_i,
	input wire logic partial_powerdown_stop_i,
	input wire logic partial_powerdown_ack_i,
	input wire logic partial_powerdown_flag_o,
	input wire logic io_locked_o,
	input wire pio_pad_t pad_o
);
	localparam logic [PIO_WIDTH-1:0] LCD = PIO_LCD_SHARED;
	// High when the pads were free to follow the registers at the previous edge
	logic live;
	always_ff @(posedge sys_clk_i)
		live <= !rst_i && !partial_powerdown_stop_i && !io_locked_o;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	sequence s_ack;
		io_locked_o && !partial_powerdown_stop_i && partial_powerdown_ack_i;
	endsequence
	ana_off_a: assert property (live |-> ((pad_o.ie | pad_o.oe | pad_o.pull_up)
		& $past(share_i.ana_en)) == 8'h00) else $error("analog pin buffer on");
	in_buf_a: assert property (live |-> pad_o.ie == ~$past(share_i.ana_en))
		else $error("input buffer wrong");
	pull_src_a: assert property (live |-> (pad_o.pull_up & ($past(share_i.dig_en)
		| ~$past(pull_o))) == 8'h00) else $error("pull-up without cause");
	pull_out_a: assert property (live |-> (pad_o.pull_up & $past(dir_o) & ~LCD) == 8'h00)
		else $error("pull-up on output");
	dig_oe_a: assert property (live |-> ((pad_o.oe ^ $past(share_i.dig_oe)) & ~LCD
		& $past(share_i.dig_en & ~share_i.ana_en)) == 8'h00) else $error("peripheral oe");
	gpio_oe_a: assert property (live |-> ((pad_o.oe ^ $past(dir_o)) & ~LCD
		& ~$past(share_i.dig_en | share_i.ana_en)) == 8'h00) else $error("direction oe");
	// Drive mode is registered once more before the pads, hence two cycles back
	od_low_a: assert property (live && !$past(lcd_supply_select_i == PIO_SUPPLY_FULL_DRIVE
		&& regulated_reference_enable_i == PIO_REG_REF_OFF, 2) && !$past(lcd_in_stop_i, 2)
		|-> (pad_o.out & LCD) == 8'h00) else $error("open drain drove high");
	in_drv_a: assert property (live |-> ((pad_o.high_drive | pad_o.slew) & ~$past(dir_o)
		& ~$past(share_i.dig_en)) == 8'h00) else $error("drive control on input");
	rd_zero_a: assert property (live |-> (rd_data_o & $past(~dir_o & share_i.ana_en)) == 8'h00)
		else $error("analog input read nonzero");
	lock_set_a: assert property (partial_powerdown_stop_i |=> io_locked_o
		&& partial_powerdown_flag_o) else $error("stop did not lock");
	pad_hold_a: assert property ((partial_powerdown_stop_i || io_locked_o) |=> $stable(pad_o))
		else $error("pads moved while locked");
	ack_clr_a: assert property (s_ack |=> !io_locked_o && !partial_powerdown_flag_o)
		else $error("ack did not unlock");
	lock_wr_a: assert property (io_locked_o |=> $stable({dir_o, pull_o, slew_o, drive_o}))
		else $error("register changed while locked");
endmodule
bind pio_port pio_port_asserts i_pio_port_asserts (.sys_clk_i, .rst_i, .rd_data_o, .dir_o,
	.pull_o, .drive_o, .slew_o, .share_i, .lcd_supply_select_i, .regulated_reference_enable_i,
	.lcd_in_stop_i,
	.partial_powerdown_stop_i, .partial_powerdown_ack_i, .partial_powerdown_flag_o,
	.io_locked_o, .pad_o);
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench for the parallel I/O port
`timescale 1ns/1ns
`default_nettype none
module tb import pio_pkg::*;;
	localparam logic [7:0] LCD = PIO_LCD_SHARED;
	logic sys_clk_i = 0;
	logic rst_i = 1;
	logic ref_en = 0, pd_stop = 0, lstop = 0, ack = 0, lcd_run = 0, od, flag, locked;
	logic [1:0] sup = 0;
	logic [7:0] ext = 0, d, dr, dv, pl, g, p, rd, dir, pull, slew, drive, pin;
	pio_wr_t wr = '0;
	pio_share_t share = '0;
	pio_pad_t pad, p0;
	int num_errors = 0;
	int compares = 0;
	always #20 sys_clk_i = ~sys_clk_i;
	pio_port i_pio_port (.sys_clk_i, .rst_i, .wr_i(wr), .rd_data_o(rd), .dir_o(dir),
		.pull_o(pull), .slew_o(slew), .drive_o(drive), .share_i(share), .lcd_supply_select_i(sup),
		.regulated_reference_enable_i(ref_en), .lcd_in_stop_i(lcd_run),
		.partial_powerdown_stop_i(pd_stop), .light_stop_i(lstop), .partial_powerdown_ack_i(ack),
		.partial_powerdown_flag_o(flag), .io_locked_o(locked), .pin_i(pin), .pad_o(pad));
	pio_load i_pio_load (.pad_i(pad), .ext_i(ext), .pin_o(pin));
	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr8(input pio_page_t pg, input pio_sel_t s, input logic [7:0] v);
		tick(1);
		wr = '{1'b1, pg, s, v};
		tick(1);
		wr.wr = 1'b0;
	endtask
	task automatic test_done;
		if (num_errors == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		void'($urandom(56));
		tick(10);
		rst_i = 0;
		chk(dir | drive | pull, 8'h00);
		chk(slew & pad.ie, 8'hFF);
		chk(pad.oe, 8'h00);
		wr8(PIO_PAGE_HIGH, PIO_SEL_DIR, 8'hFF);
		wr8(PIO_PAGE_ZERO, PIO_SEL_SLEW, 8'h00);
		tick(2);
		chk(dir | ~slew, 8'h00);
		for (int i = 0; i < 40; i++)
		begin
			{d, dr, dv, pl} = $urandom;
			{sup, ref_en} = 3'($urandom);
			share = (i < 8) ? '0 : pio_share_t'($urandom);
			ext = 8'($urandom);
			// Data goes in before direction so no stale value is driven
			wr8(PIO_PAGE_ZERO, PIO_SEL_DATA, d);
			wr8(PIO_PAGE_ZERO, PIO_SEL_DIR, dr);
			wr8(PIO_PAGE_HIGH, PIO_SEL_DRIVE, dv);
			wr8(PIO_PAGE_HIGH, PIO_SEL_PULL, pl);
			tick(6);
			g = ~(share.dig_en | share.ana_en);
			p = ~dr & g & pl;
			od = !(sup == PIO_SUPPLY_FULL_DRIVE && ref_en == PIO_REG_REF_OFF);
			chk(rd & dr, d & dr);
			chk(rd & ~dr & g & ~pl, ext & ~dr & g & ~pl);
			chk(rd & ~dr & share.ana_en, 8'h00);
			chk(rd & p, p);
			chk(pad.pull_up & p, p);
			chk(pad.oe & g & ~LCD, dr & g & ~LCD);
			chk(pad.out & dr & g & ~LCD, d & dr & g & ~LCD);
			chk(pad.high_drive & g & ~LCD, dv & dr & g & ~LCD);
			chk(pad.slew & g, dr & g);
			chk(pad.oe & g & LCD, (od ? dr & ~d : dr) & g & LCD);
			chk(pad.out & dr & g & LCD, od ? 8'h00 : d & dr & g & LCD);
			chk(pad.pull_up & g & dr, od ? pl & g & dr & LCD : 8'h00);
			chk(pad.ie, ~share.ana_en);
			chk(pad.oe & share.ana_en, 8'h00);
			chk(pad.pull_up & ~g, 8'h00);
			chk((pad.oe ^ share.dig_oe) & ~LCD & share.dig_en & ~share.ana_en, 8'h00);
		end
		share = '0;
		sup = PIO_SUPPLY_FULL_DRIVE;
		ref_en = PIO_REG_REF_OFF;
		lcd_run = 1;
		wr8(PIO_PAGE_ZERO, PIO_SEL_DATA, 8'h30);
		// Supply drops to open drain during light stop; the LCD pins must keep full drive
		lstop = 1;
		sup = 2'h0;
		wr8(PIO_PAGE_ZERO, PIO_SEL_DIR, 8'h3F);
		tick(2);
		chk(pad.oe & 8'h3F, 8'h3F);
		lstop = 0;
		lcd_run = 0;
		p0 = pad;
		pd_stop = 1;
		tick(2);
		chk({6'h00, locked, flag}, 8'h03);
		wr8(PIO_PAGE_ZERO, PIO_SEL_DIR, 8'hF0);
		ack = 1;
		tick(1);
		ack = 0;
		pd_stop = 0;
		tick(2);
		chk(dir, 8'h3F);
		chk(pad.oe, p0.oe);
		chk({7'h00, locked}, 8'h01);
		ack = 1;
		tick(1);
		ack = 0;
		tick(2);
		chk({6'h00, locked, flag}, 8'h00);
		wr8(PIO_PAGE_ZERO, PIO_SEL_DIR, 8'hF0);
		tick(1);
		chk(dir, 8'hF0);
		test_done;
	end
endmodule
`default_nettype wire
